// ===== charger_ctrl_pkg.sv
// Purpose: Shared constants for the charger mode and reverse output controller.
// Assumes: APB with 32-bit data, pclk at 200 MHz.
// Notes: Current limit codes are in 10 mA steps; pin voltage words are in mV.
package charger_ctrl_pkg;
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned START_DELAY_US    = 5000;
  localparam int unsigned START_DELAY_CYC   = START_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DELAY_W           = 21;
  localparam logic [4:0]  ADDR_CTRL         = 5'h00;
  localparam logic [4:0]  ADDR_LIMIT        = 5'h04;
  localparam logic [4:0]  ADDR_STATUS       = 5'h08;
  localparam logic [4:0]  ADDR_FLAG         = 5'h0c;
  localparam logic [4:0]  ADDR_CFG          = 5'h10;
  localparam int unsigned B_HIZ             = 0;
  localparam int unsigned B_EXT_CLAMP       = 1;
  localparam int unsigned B_SENSE_EN        = 2;
  localparam int unsigned B_FWD_PFM_DIS     = 3;
  localparam int unsigned B_FWD_OOA_DIS     = 4;
  localparam int unsigned B_REV_EN          = 5;
  localparam int unsigned B_DRV1_EN         = 6;
  localparam int unsigned B_DRV2_EN         = 7;
  localparam int unsigned B_DRV_DIS         = 8;
  localparam int unsigned B_REV_PFM_DIS     = 9;
  localparam int unsigned B_REV_OOA_DIS     = 10;
  localparam int unsigned B_CHG_EN          = 11;
  localparam int unsigned B_DREG_MASK       = 12;
  localparam logic [12:0] CTRL_RESET        = 13'h0802;
  localparam logic [8:0]  ICL_MIN_CODE      = 9'h00a;
  localparam logic [8:0]  ICL_DEFAULT_CODE  = 9'h12c;
  localparam logic [11:0] PIN_OFFSET_MV     = 12'h3e8;
  localparam logic [11:0] PIN_MIN_CLAMP_MV  = 12'h438;
  localparam int unsigned CLAMP_SHIFT       = 3;
  localparam int unsigned SENSE_UA_PER_A    = 25;
  localparam logic [5:0]  CFG_RESET         = 6'h00;
endpackage

// ===== charger_mode_ctrl.sv
// Purpose: Mode, high-impedance, input clamp and reverse output sequencing.
// Assumes: Analog comparator levels arrive asynchronously; ADC words are on pclk.
// Notes: Analog loops are outside; this block issues enables, selects, limit codes and an interrupt pulse.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module charger_mode_ctrl #(
  parameter int unsigned START_DELAY = charger_ctrl_pkg::START_DELAY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pin_adc_valid,
  input  wire logic [11:0] pin_adc_mv,
  input  wire logic        detect_valid,
  input  wire logic [8:0]  detect_code,
  input  wire logic        input_overvoltage_fault,
  input  wire logic        system_overvoltage_fault,
  input  wire logic        battery_overvoltage_fault,
  input  wire logic        reverse_output_overvoltage_fault,
  input  wire logic        system_short_fault,
  input  wire logic        input_overcurrent_fault,
  input  wire logic        pin_below_stop,
  input  wire logic        pin_above_resume,
  input  wire logic        input_above_uvlo,
  input  wire logic        battery_above_uvlo,
  input  wire logic        battery_above_reverse_threshold,
  input  wire logic        thermistor_in_window,
  input  wire logic        switch_pair_one_detected,
  input  wire logic        switch_pair_two_detected,
  input  wire logic        supplement_mode,
  input  wire logic        discharge_over_limit,
  input  wire logic        system_at_min_regulation,
  input  wire logic        charge_terminated,
  input  wire logic        battery_above_min_system,
  output logic             internal_regulator,
  output logic             converter_switching,
  output logic             battery_switch,
  output logic             reverse_mode,
  output logic             pair_one_drive,
  output logic             pair_two_drive,
  output logic [8:0]       input_current_limit,
  output logic             sense_output_enable,
  output logic             sense_report_discharge,
  output logic             light_load_mod_enable,
  output logic             audio_band_avoidance,
  output logic             reduce_output_current,
  output logic             system_above_battery,
  output logic             system_offset_high,
  output logic [1:0]       discharge_limit_field,
  output logic [1:0]       thermistor_hot_limit,
  output logic [1:0]       thermistor_cold_limit,
  output logic             interrupt_pulse
);
  import charger_ctrl_pkg::*;

  typedef enum logic [1:0] {REV_IDLE, REV_WAIT_DRIVE, REV_DELAY, REV_RUN} rev_state_t;

  // Comparator levels cross into pclk through two flops each.
  localparam int unsigned NSYNC = 19;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= {input_overvoltage_fault, system_overvoltage_fault, battery_overvoltage_fault,
                 reverse_output_overvoltage_fault, system_short_fault, input_overcurrent_fault,
                 pin_below_stop, pin_above_resume, input_above_uvlo, battery_above_uvlo,
                 battery_above_reverse_threshold, thermistor_in_window,
                 switch_pair_one_detected, switch_pair_two_detected, supplement_mode,
                 discharge_over_limit, system_at_min_regulation, charge_terminated,
                 battery_above_min_system};
      sync_b <= sync_a;
    end
  end

  logic s_in_ovp, s_sys_ovp, s_bat_ovp, s_rev_ovp, s_short, s_ocp, s_pin_low, s_pin_high;
  logic s_in_ok, s_bat_ok, s_bat_rev, s_therm, s_pair1, s_pair2, s_supp, s_dis_over, s_minsys;
  logic s_term, s_bat_min;
  assign {s_in_ovp, s_sys_ovp, s_bat_ovp, s_rev_ovp, s_short, s_ocp, s_pin_low, s_pin_high,
          s_in_ok, s_bat_ok, s_bat_rev, s_therm, s_pair1, s_pair2, s_supp, s_dis_over,
          s_minsys, s_term, s_bat_min} = sync_b;

  // APB decode; one wait state, and a write lands on the edge that completes it.
  logic       wr_stb;
  logic       rd_stb;
  logic [4:0] addr;
  logic       mapped;
  assign addr   = paddr[4:0];
  assign mapped = (paddr[31:5] == '0) && (addr == ADDR_CTRL || addr == ADDR_LIMIT ||
                  addr == ADDR_STATUS || addr == ADDR_FLAG || addr == ADDR_CFG);
  assign wr_stb = psel && penable && pwrite && pready && mapped;
  assign rd_stb = psel && penable && !pwrite && !pready;
  logic [12:0] ctrl;
  logic [5:0]  cfg;
  logic        clamp_ready;
  logic [8:0]  clamp_code;
  logic        pairs_caught;
  logic        pair1_seen;
  logic        pair2_seen;
  logic        pin_hold;
  logic        dreg_flag;
  logic        dis_over_q;
  rev_state_t  rev_state;
  rev_state_t  next_rev_state;
  logic [DELAY_W-1:0] delay_cnt;

  // Hardware set of the high-impedance bit wins over a host clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (clk_en) begin
      if (wr_stb && addr == ADDR_CTRL) begin
        ctrl <= pwdata[12:0];
      end
      if (s_short || s_ocp) begin
        ctrl[B_HIZ] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (clk_en && wr_stb && addr == ADDR_CFG) begin
      cfg <= pwdata[5:0];
    end
  end
  assign discharge_limit_field = cfg[1:0];
  assign thermistor_hot_limit  = cfg[3:2];
  assign thermistor_cold_limit = cfg[5:4];

  // Clamp from the pin word: (mV - 1000) / 800 mOhm, in 10 mA steps.
  logic [11:0] pin_excess;
  logic [8:0]  pin_clamp;
  assign pin_excess = pin_adc_mv - PIN_OFFSET_MV;
  assign pin_clamp  = (pin_adc_mv < PIN_MIN_CLAMP_MV) ? ICL_MIN_CODE :
                      pin_excess[CLAMP_SHIFT +: 9];

  // Nothing switches until the clamp is known, so the sample sees an unloaded pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_ready <= 1'b0;
      clamp_code  <= ICL_MIN_CODE;
    end else if (clk_en && !clamp_ready && pin_adc_valid) begin
      clamp_ready <= 1'b1;
      clamp_code  <= pin_clamp;
    end
  end

  // Pair detection is caught once, after the synchronisers have settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pairs_caught <= 1'b0;
      pair1_seen   <= 1'b0;
      pair2_seen   <= 1'b0;
    end else if (clk_en && clamp_ready && !pairs_caught) begin
      pairs_caught <= 1'b1;
      pair1_seen   <= s_pair1;
      pair2_seen   <= s_pair2;
    end
  end

  logic       clamp_on;
  logic [8:0] host_code;
  assign clamp_on  = ctrl[B_EXT_CLAMP];
  assign host_code = pwdata[8:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_current_limit <= ICL_DEFAULT_CODE;
    end else if (clk_en) begin
      if (!clamp_ready && pin_adc_valid) begin
        input_current_limit <= (clamp_on && ICL_DEFAULT_CODE > pin_clamp) ?
                               pin_clamp : ICL_DEFAULT_CODE;
      end else if (clamp_ready && detect_valid) begin
        input_current_limit <= (clamp_on && detect_code > clamp_code) ?
                               clamp_code : detect_code;
      end else if (wr_stb && addr == ADDR_LIMIT) begin
        input_current_limit <= (clamp_on && clamp_ready && host_code > clamp_code) ?
                               clamp_code : host_code;
      end
    end
  end

  // Pin hysteresis between the stop and resume comparators.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_hold <= 1'b0;
    end else if (clk_en) begin
      if (s_pin_low) begin
        pin_hold <= 1'b1;
      end else if (s_pin_high) begin
        pin_hold <= 1'b0;
      end
    end
  end

  logic hiz;
  logic ov_fault;
  logic rev_allowed;
  logic drive_ok;
  logic use_pairs;
  assign hiz         = ctrl[B_HIZ];
  assign ov_fault    = s_in_ovp || s_sys_ovp || s_bat_ovp || s_rev_ovp;
  assign rev_allowed = ctrl[B_REV_EN] && s_bat_rev && !s_bat_ovp && !s_in_ok && s_therm;
  assign use_pairs   = !ctrl[B_DRV_DIS] && (pair1_seen || pair2_seen);
  assign drive_ok    = (pair1_seen && ctrl[B_DRV1_EN]) ||
                       (pair2_seen && ctrl[B_DRV2_EN]);

  always_comb begin
    next_rev_state = rev_state;
    case (rev_state)
      REV_IDLE: begin
        if (rev_allowed && pairs_caught && !hiz) begin
          next_rev_state = use_pairs ? REV_WAIT_DRIVE : REV_DELAY;
        end
      end
      REV_WAIT_DRIVE: begin
        if (drive_ok) begin
          next_rev_state = REV_DELAY;
        end
      end
      REV_DELAY: begin
        if (delay_cnt == DELAY_W'(START_DELAY - 1)) begin
          next_rev_state = REV_RUN;
        end
      end
      REV_RUN: begin
        next_rev_state = REV_RUN;
      end
      default: begin
        next_rev_state = REV_IDLE;
      end
    endcase
    if (rev_state != REV_IDLE && (!rev_allowed || hiz)) begin
      next_rev_state = REV_IDLE;
    end else if (rev_state != REV_IDLE && use_pairs && !drive_ok) begin
      next_rev_state = REV_WAIT_DRIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_state <= REV_IDLE;
      delay_cnt <= '0;
    end else if (clk_en) begin
      rev_state <= next_rev_state;
      if (next_rev_state == REV_DELAY && rev_state == REV_DELAY) begin
        delay_cnt <= delay_cnt + DELAY_W'(1);
      end else begin
        delay_cnt <= '0;
      end
    end
  end

  logic rev_active;
  logic rev_run;
  assign rev_active = ctrl[B_REV_EN];
  assign rev_run    = (rev_state == REV_RUN);

  // Converter and power path enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_regulator  <= 1'b0;
      converter_switching <= 1'b0;
      battery_switch      <= 1'b1;
      reverse_mode        <= 1'b0;
      pair_one_drive      <= 1'b0;
      pair_two_drive      <= 1'b0;
    end else if (clk_en) begin
      internal_regulator  <= !hiz;
      converter_switching <= clamp_ready && !hiz && !ov_fault && !pin_hold &&
                             (rev_active ? rev_run : s_in_ok);
      battery_switch      <= hiz || !s_in_ok || rev_active;
      reverse_mode        <= rev_active && rev_state != REV_IDLE;
      pair_one_drive      <= use_pairs && pair1_seen && ctrl[B_DRV1_EN];
      pair_two_drive      <= use_pairs && pair2_seen && ctrl[B_DRV2_EN];
    end
  end

  // Sense output gain is fixed in the analog path at SENSE_UA_PER_A per ampere.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_output_enable    <= 1'b0;
      sense_report_discharge <= 1'b0;
    end else if (clk_en) begin
      sense_output_enable    <= (s_in_ok || s_bat_ok) && ctrl[B_SENSE_EN] &&
                                !(s_in_ok && !rev_active && s_supp);
      sense_report_discharge <= rev_active || !s_in_ok;
    end
  end

  // Light-load modulation off means fixed frequency with DCM at light load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      light_load_mod_enable <= 1'b1;
      audio_band_avoidance  <= 1'b1;
      system_offset_high    <= 1'b1;
      system_above_battery  <= 1'b0;
    end else if (clk_en) begin
      light_load_mod_enable <= rev_active ? !ctrl[B_REV_PFM_DIS] :
                                            !ctrl[B_FWD_PFM_DIS];
      audio_band_avoidance  <= rev_active ? !ctrl[B_REV_OOA_DIS] :
                                            !ctrl[B_FWD_OOA_DIS];
      system_offset_high    <= !ctrl[B_FWD_PFM_DIS];
      system_above_battery  <= (!ctrl[B_CHG_EN] || s_term) && s_bat_min;
    end
  end

  // Discharge regulation: flag set wins over a host clear in the same cycle.
  logic dreg_rise;
  logic flag_clear;
  assign dreg_rise  = rev_run && s_dis_over && !dis_over_q;
  assign flag_clear = wr_stb && addr == ADDR_FLAG && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_over_q            <= 1'b0;
      dreg_flag             <= 1'b0;
      reduce_output_current <= 1'b0;
      interrupt_pulse       <= 1'b0;
    end else if (clk_en) begin
      dis_over_q            <= rev_run && s_dis_over;
      reduce_output_current <= rev_run && s_dis_over;
      interrupt_pulse       <= dreg_rise && !ctrl[B_DREG_MASK];
      if (dreg_rise) begin
        dreg_flag <= 1'b1;
      end else if (flag_clear) begin
        dreg_flag <= 1'b0;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (addr)
      ADDR_CTRL:   rd_mux = {19'h0, ctrl};
      ADDR_LIMIT:  rd_mux = {7'h0, clamp_code, 7'h0, input_current_limit};
      ADDR_STATUS: rd_mux = {22'h0, s_minsys, reduce_output_current, rev_state,
                             pair2_seen, pair1_seen, converter_switching, pin_hold,
                             clamp_ready, hiz};
      ADDR_FLAG:   rd_mux = {31'h0, dreg_flag};
      ADDR_CFG:    rd_mux = {26'h0, cfg};
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= (rd_stb && mapped) ? rd_mux : '0;
    end
  end
endmodule
`default_nettype wire

// ===== charger_mode_ctrl_monitor.sv
// Purpose: Port-level checker for the charger mode controller.
// Assumes: Async level inputs settle through two flops plus one output flop.
// Notes: Repetition counts allow some slack over the synchroniser latency.
`timescale 1ns/1ps
`default_nettype none
module charger_mode_ctrl_check (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pin_adc_valid,
  input wire logic [11:0] pin_adc_mv,
  input wire logic        input_overvoltage_fault,
  input wire logic        system_overvoltage_fault,
  input wire logic        battery_overvoltage_fault,
  input wire logic        reverse_output_overvoltage_fault,
  input wire logic        system_short_fault,
  input wire logic        input_overcurrent_fault,
  input wire logic        pin_below_stop,
  input wire logic        input_above_uvlo,
  input wire logic        battery_above_uvlo,
  input wire logic        supplement_mode,
  input wire logic        internal_regulator,
  input wire logic        converter_switching,
  input wire logic        battery_switch,
  input wire logic        reverse_mode,
  input wire logic [8:0]  input_current_limit,
  input wire logic        sense_output_enable,
  input wire logic        light_load_mod_enable,
  input wire logic        system_above_battery,
  input wire logic        system_offset_high,
  input wire logic        interrupt_pulse
);
  import charger_ctrl_pkg::*;
  logic [11:0] mv_over;
  logic [8:0]  exp_clamp;
  logic        any_ov;
  // The limit set from the pin sample never exceeds the default limit, so the expectation saturates too.
  always_comb begin
    mv_over   = pin_adc_mv - PIN_OFFSET_MV;
    exp_clamp = 9'(mv_over >> CLAMP_SHIFT);
    if (exp_clamp > ICL_DEFAULT_CODE) begin
      exp_clamp = ICL_DEFAULT_CODE;
    end
  end
  assign any_ov = input_overvoltage_fault | system_overvoltage_fault |
                  battery_overvoltage_fault | reverse_output_overvoltage_fault;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hiz_state: assert property (
    !internal_regulator |-> !converter_switching && battery_switch)
    else $error("regulator off while converter switching");
  a_ov_stop: assert property (any_ov [*5] |-> !converter_switching)
    else $error("switching during overvoltage");
  a_short_hiz: assert property (
    (system_short_fault || input_overcurrent_fault) [*6] |-> !internal_regulator)
    else $error("short or overcurrent left regulator on");
  a_pin_stop: assert property (pin_below_stop [*5] |-> !converter_switching)
    else $error("switching with pin below stop level");
  a_clamp_min: assert property (
    pin_adc_valid && pin_adc_mv < PIN_MIN_CLAMP_MV |-> ##[1:3]
    input_current_limit == ICL_MIN_CODE)
    else $error("low pin did not give minimum clamp");
  a_clamp_calc: assert property (
    pin_adc_valid && pin_adc_mv >= PIN_MIN_CLAMP_MV |-> ##[1:3]
    input_current_limit == exp_clamp)
    else $error("clamp differs from pin reading");
  a_sense_uvlo: assert property (
    (!input_above_uvlo && !battery_above_uvlo) [*5] |-> !sense_output_enable)
    else $error("sense enabled without supply");
  a_sense_supp: assert property (supplement_mode [*5] |-> !sense_output_enable)
    else $error("sense enabled in supplement mode");
  a_irq_pulse: assert property (
    interrupt_pulse |-> reverse_mode ##1 !interrupt_pulse)
    else $error("interrupt pulse wrong");
  a_offset_sel: assert property (
    system_above_battery |-> system_offset_high == light_load_mod_enable)
    else $error("system offset does not follow modulation");
endmodule
bind charger_mode_ctrl charger_mode_ctrl_check u_chk (.pclk(pclk), .presetn(presetn),
  .pin_adc_valid(pin_adc_valid), .pin_adc_mv(pin_adc_mv),
  .input_overvoltage_fault(input_overvoltage_fault),
  .system_overvoltage_fault(system_overvoltage_fault),
  .battery_overvoltage_fault(battery_overvoltage_fault),
  .reverse_output_overvoltage_fault(reverse_output_overvoltage_fault),
  .system_short_fault(system_short_fault), .input_overcurrent_fault(input_overcurrent_fault),
  .pin_below_stop(pin_below_stop), .input_above_uvlo(input_above_uvlo),
  .battery_above_uvlo(battery_above_uvlo), .supplement_mode(supplement_mode),
  .internal_regulator(internal_regulator), .converter_switching(converter_switching),
  .battery_switch(battery_switch), .reverse_mode(reverse_mode),
  .input_current_limit(input_current_limit), .sense_output_enable(sense_output_enable),
  .light_load_mod_enable(light_load_mod_enable), .system_above_battery(system_above_battery),
  .system_offset_high(system_offset_high), .interrupt_pulse(interrupt_pulse));
`default_nettype wire

// ===== host_apb_model.sv
// Purpose: Host processor model that programs the charger over APB.
// Assumes: One transfer at a time; pready is sampled at rising edges.
// Notes: The request is held until pready, as a real master must.
`timescale 1ns/1ps
`default_nettype none
module host_apb_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata
);
  logic err;
  initial {psel, penable, pwrite, paddr, pwdata, err} = '0;
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {27'h0, a};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== charger_mode_ctrl_tb_top.sv
// Purpose: Self-checking bench for the charger mode controller.
// Assumes: Start delay shortened to 20 cycles.
// Notes: Waits of five cycles cover the input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module charger_mode_ctrl_tb_top;
  import charger_ctrl_pkg::*;
  localparam int SD = 20;
  localparam logic [31:0] C0 = 32'(CTRL_RESET);
  logic pclk = 1'b0, presetn = 1'b0, adc_v = 1'b0;
  logic [11:0] adc_mv = 12'h708;
  logic [5:0] flt = 6'h00;
  logic stop = 1'b0, resume = 1'b1, in_uv = 1'b0, bat_uv = 1'b0, bat_rev = 1'b1;
  logic therm = 1'b0, p1 = 1'b0, p2 = 1'b0, supp = 1'b0, dover = 1'b0;
  logic at_min = 1'b0, term = 1'b0, amin = 1'b0, dv = 1'b0, ce = 1'b1, seen;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, d;
  logic reg_on, sw, bsw, rev, d1, d2, sen, sdis, llm, aba, red, sab, soh, irq;
  logic [8:0] icl, dc = 9'h000;
  logic [1:0] dlf, hot, cold;
  int miscompares = 0, checked = 0;
  initial forever #2.5 pclk = ~pclk;
  host_apb_model host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  charger_mode_ctrl #(.START_DELAY(SD)) DUT (.pclk, .presetn, .clk_en(ce), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_adc_valid(adc_v),
    .pin_adc_mv(adc_mv), .detect_valid(dv), .detect_code(dc),
    .input_overvoltage_fault(flt[0]), .system_overvoltage_fault(flt[1]),
    .battery_overvoltage_fault(flt[2]), .reverse_output_overvoltage_fault(flt[3]),
    .system_short_fault(flt[4]), .input_overcurrent_fault(flt[5]), .pin_below_stop(stop),
    .pin_above_resume(resume), .input_above_uvlo(in_uv), .battery_above_uvlo(bat_uv),
    .battery_above_reverse_threshold(bat_rev), .thermistor_in_window(therm),
    .switch_pair_one_detected(p1), .switch_pair_two_detected(p2), .supplement_mode(supp),
    .discharge_over_limit(dover), .system_at_min_regulation(at_min),
    .charge_terminated(term), .battery_above_min_system(amin), .internal_regulator(reg_on),
    .converter_switching(sw), .battery_switch(bsw), .reverse_mode(rev), .pair_one_drive(d1),
    .pair_two_drive(d2), .input_current_limit(icl), .sense_output_enable(sen),
    .sense_report_discharge(sdis), .light_load_mod_enable(llm), .audio_band_avoidance(aba),
    .reduce_output_current(red), .system_above_battery(sab), .system_offset_high(soh),
    .discharge_limit_field(dlf), .thermistor_hot_limit(hot), .thermistor_cold_limit(cold),
    .interrupt_pulse(irq));
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [4:0] a);
    host.xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic power_on(input logic [11:0] mv, input logic [1:0] pr);
    presetn <= 1'b0;
    {p2, p1} <= pr;
    adc_mv <= mv;
    tick(3);
    presetn <= 1'b1;
    tick(4);
    adc_v <= 1'b1;
    tick(1);
    adc_v <= 1'b0;
    tick(5);
  endtask
  // A converter start must wait the whole delay, then arrive promptly.
  task automatic run_chk(input logic [31:0] v);
    wr(ADDR_CTRL, v);
    tick(SD + 2);
    chk("early start", sw, 0);
    tick(1);
    chk("start", sw, 1);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    power_on(12'h41a, 2'b00);
    rd(ADDR_LIMIT);
    chk("low clamp", d[8:0], 9'h00a);
    power_on(12'h708, 2'b00);
    chk("limit", icl, 9'h064);
    {dv, dc} <= {1'b1, 9'h032};
    tick(1);
    {dv, dc} <= {1'b1, 9'h1f4};
    tick(1);
    chk("detect", icl, 9'h032);
    dv <= 1'b0;
    tick(1);
    chk("detect clamp", icl, 9'h064);
    rd(ADDR_LIMIT);
    chk("clamp", d[24:16], 9'h064);
    wr(ADDR_LIMIT, 32'h1ff);
    rd(ADDR_LIMIT);
    chk("saturate", d[8:0], 9'h064);
    wr(ADDR_CTRL, C0 & ~32'h2);
    wr(ADDR_LIMIT, 32'h1ff);
    rd(ADDR_LIMIT);
    chk("no clamp", d[8:0], 9'h1ff);
    rd(5'h14);
    chk("unmapped", {d[30:0], host.err}, 32'h1);
    $display("test clamp done");
    in_uv <= 1'b1;
    wr(ADDR_CTRL, C0 | 32'h1);
    tick(5);
    chk("hiz", {reg_on, sw, bsw}, 32'h1);
    wr(ADDR_CTRL, C0);
    tick(5);
    chk("resume", {reg_on, sw}, 32'h3);
    for (int i = 0; i < 6; i++) begin
      flt <= 6'(1 << i);
      tick(6);
      rd(ADDR_CTRL);
      if (i < 4) chk("ov", {d[0], reg_on, sw}, 32'h2);
      else chk("short", {d[0], reg_on}, 32'h2);
      flt <= 6'h00;
      tick(5);
      wr(ADDR_CTRL, C0);
      tick(5);
      chk("recover", {reg_on, sw}, 32'h3);
    end
    stop <= 1'b1;
    resume <= 1'b0;
    tick(5);
    chk("pin stop", {reg_on, sw}, 32'h2);
    stop <= 1'b0;
    tick(5);
    chk("pin hold", sw, 0);
    resume <= 1'b1;
    tick(5);
    chk("pin resume", sw, 1);
    {ce, in_uv} <= 2'b00;
    tick(5);
    chk("frozen", sw, 1);
    {ce, in_uv} <= 2'b11;
    $display("test hiz and faults done");
    bat_uv <= 1'b1;
    wr(ADDR_CTRL, C0 | 32'h1c);
    tick(5);
    chk("fwd modes", {sen, sdis, llm, aba}, 32'h8);
    supp <= 1'b1;
    tick(5);
    chk("supplement", sen, 0);
    supp <= 1'b0;
    at_min <= 1'b1;
    tick(5);
    rd(ADDR_STATUS);
    chk("min sys", d[9], 1);
    amin <= 1'b1;
    term <= 1'b1;
    tick(5);
    chk("terminated", {sab, soh}, 32'h2);
    term <= 1'b0;
    wr(ADDR_CTRL, 32'h2);
    tick(5);
    chk("chg off", {sab, soh}, 32'h3);
    wr(ADDR_CFG, 32'h39);
    tick(2);
    chk("cfg", {cold, hot, dlf}, 32'h39);
    wr(ADDR_CTRL, C0);
    {amin, at_min, in_uv} <= 3'b000;
    $display("test forward modes done");
    wr(ADDR_CTRL, C0 | 32'h20);
    tick(40);
    chk("thermistor", sw, 0);
    wr(ADDR_CTRL, C0);
    therm <= 1'b1;
    tick(5);
    for (int m = 0; m < 2; m++) begin
      run_chk(C0 | 32'h624 | 32'(m << 12));
      chk("rev modes", {rev, sdis, llm, aba}, 32'hc);
      dover <= 1'b1;
      seen = 1'b0;
      repeat (8) begin
        tick(1);
        seen |= irq;
      end
      chk("irq", {seen, red}, m ? 32'h1 : 32'h3);
      rd(ADDR_FLAG);
      chk("flag", d[0], 1);
      dover <= 1'b0;
      wr(ADDR_FLAG, 32'h1);
      rd(ADDR_FLAG);
      chk("flag clr", d[0], 0);
      wr(ADDR_CTRL, C0);
      tick(5);
    end
    $display("test reverse done");
    power_on(12'h708, 2'b01);
    wr(ADDR_CTRL, C0 | 32'h20);
    tick(40);
    chk("one pair wait", sw, 0);
    run_chk(C0 | 32'h60);
    chk("pair1 on", d1, 1);
    power_on(12'h708, 2'b11);
    wr(ADDR_CTRL, C0 | 32'h20);
    tick(40);
    chk("two pair wait", sw, 0);
    run_chk(C0 | 32'ha0);
    chk("pair2 on", {d1, d2}, 32'h1);
    wr(ADDR_CTRL, C0 | 32'h20);
    tick(5);
    chk("swap stop", sw, 0);
    run_chk(C0 | 32'h60);
    chk("swap pair", {d1, d2}, 32'h2);
    wr(ADDR_CTRL, C0);
    tick(5);
    run_chk(C0 | 32'h120);
    chk("drive off", {d1, d2}, 32'h0);
    $display("test pairs done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
